/* File: lscl_host_model.sv */
`timescale 1ns/10ps
`default_nettype none

module lscl_host_model (
  // serial link towards the device
  output logic ser_clk,
  output logic ser_data,
  output logic latch_strobe,
  output logic reset_pin_n
);
  // ------------------------------------------------------------
  // power-up and frame sending
  // ------------------------------------------------------------
  initial begin
    ser_clk = 1'b0;
    ser_data = 1'b0;
    latch_strobe = 1'b0;
    reset_pin_n = 1'b0;
    #600 reset_pin_n = 1'b1; // supply taken as settled by now
  end

  // bit 0 goes first; the clock idles low between frames
  task automatic send(input logic [63:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      ser_data = bits[i];
      #6 ser_clk = 1'b1;
      #6 ser_clk = 1'b0;
    end
    ser_data = ~ser_data; // idle line shows no stale bit between frames
    #150 latch_strobe = 1'b1; // clock kept quiet around the load
    #300 latch_strobe = 1'b0;
    #300;
  endtask : send

  task automatic pin_reset();
    reset_pin_n = 1'b0;
    #300 reset_pin_n = 1'b1;
  endtask : pin_reset
endmodule : lscl_host_model

`default_nettype wire

/* File: lscl_pkg.sv */
package lscl_pkg;

  // ------------------------------------------------------------
  // frame layout
  // ------------------------------------------------------------
  localparam int SEG_BITS = 40;
  localparam int CMD_BITS = 6;
  localparam int FRAME_BITS = SEG_BITS + CMD_BITS;
  localparam int ROWS = 4;
  localparam int ROW_SEL_LSB = 0;
  localparam int OPCODE_LSB = 2;
  localparam int CMD_LSB = SEG_BITS;

  // ------------------------------------------------------------
  // opcodes in the upper four command bits
  // ------------------------------------------------------------
  localparam logic [3:0] OP_ROW_WRITE = 4'h2;
  localparam logic [3:0] OP_BLANK = 4'hA;
  localparam logic [3:0] OP_UNBLANK = 4'hB;

  // ------------------------------------------------------------
  // apb register map (byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_ROW_LO = 8'h08;
  localparam logic [7:0] ADDR_ROW_HI = 8'h0C;

  // ctrl fields
  localparam int CTRL_OUT_EN_BIT = 0;
  localparam int CTRL_ROW_SEL_LSB = 4;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;

  // status fields
  localparam int STAT_BLANKED_BIT = 0;
  localparam int STAT_PIN_RST_BIT = 1;
  localparam int STAT_CMD_LSB = 8;
  localparam int STAT_FRAMES_LSB = 16;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic BLANKED_RESET = 1'b1;
  localparam logic [15:0] FRAMES_RESET = 16'h0000;

endpackage : lscl_pkg

/* File: lscl_sync.sv */
`timescale 1ns/10ps
`default_nettype none

module lscl_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  // ------------------------------------------------------------
  // two flops; stage1 feeds nothing but stage two
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      stage1 <= INIT;
      sync_out <= INIT;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end

endmodule : lscl_sync

`default_nettype wire

/* File: lscl_top.sv */
// The APB slave port and the register addresses were decided locally.
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// - a frame is 40 segment bits followed by a six-bit command
// - serial data enters the shift register on each serial clock rise
// - on strobe with a row write the shifted segment data goes to the chosen row latch
// - opcode 0010 writes row 0..3 as given by the two low bits
// - after reset the display stays blanked until an unblank command
// - opcode 1010 forces every segment output off
// - opcode 1011 leaves blanking, outputs show retained latches again
// - all other opcodes do nothing to the latches
// - blank and unblank work with only the four opcode bits shifted
// - command is taken from the six newest bits at strobe rise
module lscl_top (
  // core clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial link from the host
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic latch_strobe,
  input wire logic reset_pin_n,
  // display side
  output logic [lscl_pkg::ROWS*lscl_pkg::SEG_BITS-1:0] seg_rows,
  output logic display_blank
);

  localparam int SB = lscl_pkg::SEG_BITS;
  localparam int FB = lscl_pkg::FRAME_BITS;
  localparam int NR = lscl_pkg::ROWS;

  // ------------------------------------------------------------
  // link domain: shift register
  // ------------------------------------------------------------
  // new bit enters at the top, so after a full frame the command sits
  // in the top six bits with its highest bit at the very top and
  // segment bit one at bit zero; padding falls off the bottom
  logic [FB-1:0] shreg;

  always_ff @(posedge ser_clk) begin
    shreg <= {ser_data, shreg[FB-1:1]};
  end

  AST_TOP_BIT: assert property (
    @(posedge ser_clk) disable iff (reset)
    1'b1 |=> shreg[FB-1] == $past(ser_data))
    else $error("newest serial bit not at the top of the register");

  // ------------------------------------------------------------
  // crossing of strobe and reset pin
  // ------------------------------------------------------------
  // shreg is not synchronised bit by bit: the host keeps the serial
  // clock still around the strobe, so it is quiet when sampled here.
  // limitation: the strobe rise is seen two to three core cycles late
  logic strobe_s;
  logic pin_rst_n_s;
  logic strobe_q;
  logic strobe_rise;

  // idle levels at reset, so no false strobe edge follows reset
  lscl_sync #(
    .WIDTH(2),
    .INIT(2'h2)
  ) u_sync (
    .clk(core_clk),
    .reset(reset),
    .async_in({reset_pin_n, latch_strobe}),
    .sync_out({pin_rst_n_s, strobe_s})
  );

  always_ff @(posedge core_clk) begin
    if (reset) begin
      strobe_q <= 1'b0;
    end else begin
      strobe_q <= strobe_s;
    end
  end

  assign strobe_rise = strobe_s & ~strobe_q;

  // ------------------------------------------------------------
  // command decode
  // ------------------------------------------------------------
  logic [lscl_pkg::CMD_BITS-1:0] cmd;
  logic [3:0] opcode;
  logic [1:0] row_sel;
  logic [SB-1:0] seg_field;

  assign cmd = shreg[FB-1:lscl_pkg::CMD_LSB];
  assign opcode = cmd[lscl_pkg::OPCODE_LSB +: 4];
  // low two bits pick the row; only row writes look at them
  assign row_sel = cmd[lscl_pkg::ROW_SEL_LSB +: 2];
  assign seg_field = shreg[SB-1:0];

  // ------------------------------------------------------------
  // row latches
  // ------------------------------------------------------------
  logic [NR-1:0][SB-1:0] latch;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      latch <= '0;
    end else if (strobe_rise && opcode == lscl_pkg::OP_ROW_WRITE) begin
      latch[row_sel] <= seg_field;
    end
  end

  // a load may come only from a strobe, and only into the chosen row
  sequence s_row_load;
    strobe_rise && opcode == lscl_pkg::OP_ROW_WRITE;
  endsequence

  AST_NO_LOAD: assert property (
    @(posedge core_clk) disable iff (reset)
    !strobe_rise |=> $stable(latch))
    else $error("latch changed without a strobe");

  for (genvar k = 0; k < NR; k++) begin : g_keep
    AST_ROW_KEEP: assert property (
      @(posedge core_clk) disable iff (reset)
      strobe_rise && row_sel != 2'(k) |=> $stable(latch[k]))
      else $error("row write touched a row it did not select");
  end

  // ------------------------------------------------------------
  // blanking state
  // ------------------------------------------------------------
  logic blanked;

  always_ff @(posedge core_clk) begin
    if (reset || !pin_rst_n_s) begin
      blanked <= lscl_pkg::BLANKED_RESET;
    end else if (strobe_rise) begin
      case (opcode)
        lscl_pkg::OP_BLANK: begin
          blanked <= 1'b1;
        end
        lscl_pkg::OP_UNBLANK: begin
          blanked <= 1'b0;
        end
        default: begin
          blanked <= blanked;
        end
      endcase
    end
  end

  // the pin is a second source of blanking beside the core reset
  AST_PIN_BLANK: assert property (
    @(posedge core_clk) disable iff (reset)
    !pin_rst_n_s |=> blanked)
    else $error("reset pin did not blank the display");

  // ------------------------------------------------------------
  // apb registers
  // ------------------------------------------------------------
  logic [31:0] ctrl;
  logic [15:0] frames;
  logic [lscl_pkg::CMD_BITS-1:0] last_cmd;
  logic out_en;
  logic [1:0] rd_row;
  logic setup;
  logic access;
  logic addr_ok;
  logic [31:0] next_prdata;
  logic [2*SB-1:0] rd_pair;

  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign out_en = ctrl[lscl_pkg::CTRL_OUT_EN_BIT];
  assign rd_row = ctrl[lscl_pkg::CTRL_ROW_SEL_LSB +: 2];
  assign rd_pair = {{(2*SB-SB){1'b0}}, latch[rd_row]};
  assign addr_ok = paddr == lscl_pkg::ADDR_CTRL
                || paddr == lscl_pkg::ADDR_STATUS
                || paddr == lscl_pkg::ADDR_ROW_LO
                || paddr == lscl_pkg::ADDR_ROW_HI;

  always_comb begin
    next_prdata = 32'h0000_0000;
    case (paddr)
      lscl_pkg::ADDR_CTRL: begin
        next_prdata = ctrl;
      end
      lscl_pkg::ADDR_STATUS: begin
        next_prdata[lscl_pkg::STAT_BLANKED_BIT] = blanked;
        next_prdata[lscl_pkg::STAT_PIN_RST_BIT] = ~pin_rst_n_s;
        next_prdata[lscl_pkg::STAT_CMD_LSB +: 6] = last_cmd;
        next_prdata[lscl_pkg::STAT_FRAMES_LSB +: 16] = frames;
      end
      lscl_pkg::ADDR_ROW_LO: begin
        next_prdata = rd_pair[31:0];
      end
      lscl_pkg::ADDR_ROW_HI: begin
        next_prdata = rd_pair[63:32];
      end
      default: begin
        next_prdata = 32'h0000_0000;
      end
    endcase
  end

  // read data settles at the setup edge, so no wait state is needed
  always_ff @(posedge core_clk) begin
    if (reset) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata <= pwrite ? 32'h0000_0000 : next_prdata;
      pslverr <= ~addr_ok;
    end
  end

  // no wait states: the slave never stalls the bus
  assign pready = 1'b1;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      ctrl <= lscl_pkg::CTRL_RESET;
    end else if (access && pwrite && paddr == lscl_pkg::ADDR_CTRL) begin
      // only enable and row select are kept; other bits read as zero
      ctrl <= pwdata & 32'h0000_0031;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      frames <= lscl_pkg::FRAMES_RESET;
      last_cmd <= 6'h00;
    end else if (strobe_rise) begin
      frames <= frames + 16'h0001;
      last_cmd <= cmd;
    end
  end

  // ------------------------------------------------------------
  // segment outputs
  // ------------------------------------------------------------
  // registered, so the row mux cannot glitch the segment pins
  genvar r;
  generate
    for (r = 0; r < NR; r = r + 1) begin : g_row
      always_ff @(posedge core_clk) begin
        if (reset) begin
          seg_rows[r*SB +: SB] <= '0;
        end else if (blanked || !out_en) begin
          seg_rows[r*SB +: SB] <= '0;
        end else begin
          seg_rows[r*SB +: SB] <= latch[r];
        end
      end
    end
  endgenerate

  assign display_blank = blanked;

  sequence s_shown;
    !blanked && out_en;
  endsequence

  AST_BLANK_OUT: assert property (
    @(posedge core_clk) disable iff (reset)
    blanked |=> seg_rows == '0)
    else $error("segment output on while blanked");

  // two steps: the latch loads, then the visible row follows
  AST_ROW_VIEW: assert property (
    @(posedge core_clk) disable iff (reset)
    s_row_load ##1 s_shown
      |=> seg_rows[$past(row_sel, 2)*SB +: SB] == $past(seg_field, 2))
    else $error("loaded row did not reach the segment outputs");

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  sequence s_cmd(logic [3:0] op);
    strobe_rise && opcode == op;
  endsequence

  sequence s_live;
    !reset && pin_rst_n_s;
  endsequence

  AST_SHIFT_IN: assert property (
    @(posedge ser_clk) disable iff (reset)
    1'b1 |=> ##1 shreg[FB-2] == $past(ser_data, 2))
    else $error("serial bit not shifted on clock rise");

  AST_ROW_WRITE: assert property (
    @(posedge core_clk) disable iff (reset)
    s_cmd(lscl_pkg::OP_ROW_WRITE)
      |=> latch[$past(row_sel)] == $past(seg_field))
    else $error("row write did not load chosen latch");

  AST_IGNORED: assert property (
    @(posedge core_clk) disable iff (reset)
    strobe_rise && opcode != lscl_pkg::OP_ROW_WRITE
      |=> $stable(latch))
    else $error("ignored command changed a latch");

  AST_BLANK: assert property (
    @(posedge core_clk) disable iff (reset)
    s_cmd(lscl_pkg::OP_BLANK) |=> blanked ##1 seg_rows == '0)
    else $error("blank command did not clear outputs");

  AST_UNBLANK: assert property (
    @(posedge core_clk) disable iff (reset)
    s_cmd(lscl_pkg::OP_UNBLANK) ##0 s_live ##1 pin_rst_n_s
      |-> !blanked)
    else $error("unblank command did not leave blanking");

  AST_RESET_BLANK: assert property (
    @(posedge core_clk)
    reset |=> blanked && seg_rows == '0)
    else $error("reset did not blank the display");

  AST_HOLD_BLANK: assert property (
    @(posedge core_clk) disable iff (reset)
    blanked && !(strobe_rise && opcode == lscl_pkg::OP_UNBLANK)
      |=> blanked)
    else $error("blanking left without unblank command");

  AST_SEG_VIEW: assert property (
    @(posedge core_clk) disable iff (reset)
    !blanked && out_en |=> seg_rows == $past(latch))
    else $error("outputs do not follow latches");

  AST_CMD_FIELD: assert property (
    @(posedge core_clk) disable iff (reset)
    strobe_rise |=> last_cmd == $past(shreg[FB-1:SB]))
    else $error("command not taken from newest six bits");

endmodule : lscl_top

`default_nettype wire

/* File: test_lcd_serial_command_latch.sv */
`timescale 1ns/10ps
`default_nettype none

module test_lcd_serial_command_latch;
  logic core_clk, reset, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic ser_clk, ser_data, latch_strobe, reset_pin_n, display_blank, err;
  logic [159:0] seg_rows, rows;
  logic [39:0] pat;
  int failures, n_tests;

  lscl_top dut_u (.core_clk(core_clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ser_clk(ser_clk),
    .ser_data(ser_data), .latch_strobe(latch_strobe),
    .reset_pin_n(reset_pin_n), .seg_rows(seg_rows),
    .display_blank(display_blank));
  lscl_host_model host_u (.ser_clk(ser_clk), .ser_data(ser_data),
    .latch_strobe(latch_strobe), .reset_pin_n(reset_pin_n));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  task automatic report_and_stop();
    if (failures == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    #2000000;
    failures++;
    report_and_stop();
  end

  task automatic chk(input logic [159:0] got, input logic [159:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // frame: segment 1 first, command bit 5 last; pad adds 3 leading bits
  task automatic frame(input logic [5:0] c, input logic [39:0] s,
                       input logic pad);
    host_u.send(pad ? {15'h0, c, s, 3'b101} : {18'h0, c, s},
                pad ? 49 : 46);
    repeat (2) @(posedge core_clk);
  endtask : frame

  task automatic cmd4(input logic [3:0] op);
    host_u.send({60'h0, op}, 4);
    repeat (2) @(posedge core_clk);
  endtask : cmd4

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    failures = 0;
    n_tests = 0;
    rows = 160'h0;
    repeat (10) @(posedge core_clk);
    reset <= 1'b0;
    repeat (20) @(posedge core_clk);
    chk(display_blank, 1'b1);
    chk(seg_rows, 160'h0);
    chk(pready, 1'b1);
    apb(1'b0, lscl_pkg::ADDR_CTRL, 32'h0);
    chk(rd, lscl_pkg::CTRL_RESET);
    chk(err, 1'b0);
    apb(1'b0, 8'h10, 32'h0);
    chk(err, 1'b1);
    for (int r = 0; r < 4; r++) begin
      pat = 40'hF0_1234_5678 ^ (40'h11 << (8 * r));
      frame({lscl_pkg::OP_ROW_WRITE, 2'(r)}, pat, 1'b0);
      rows[r*40 +: 40] = pat;
      chk(seg_rows, 160'h0);
    end
    cmd4(lscl_pkg::OP_UNBLANK);
    chk(seg_rows, rows);
    apb(1'b1, lscl_pkg::ADDR_CTRL, 32'h31);
    apb(1'b0, lscl_pkg::ADDR_ROW_HI, 32'h0);
    chk(rd, {24'h0, rows[159:152]});
    apb(1'b0, lscl_pkg::ADDR_ROW_LO, 32'h0);
    chk(rd, rows[151:120]);
    apb(1'b0, lscl_pkg::ADDR_STATUS, 32'h0);
    chk(rd[0], 1'b0);
    chk(rd[1], 1'b0);
    chk(rd[13:8], 6'h2C);
    chk(rd[31:16], 16'h0005);
    for (int op = 0; op < 16; op++) begin
      if (op != 2 && op != 10 && op != 11) begin
        frame({4'(op), 2'b01}, ~pat, 1'b0);
        chk(seg_rows, rows);
      end
    end
    frame({lscl_pkg::OP_ROW_WRITE, 2'b01}, 40'h1, 1'b1);
    rows[79:40] = 40'h1;
    chk(seg_rows, rows);
    apb(1'b1, lscl_pkg::ADDR_CTRL, 32'h10);
    apb(1'b0, lscl_pkg::ADDR_ROW_LO, 32'h0);
    chk(rd, 32'h0000_0001);
    apb(1'b0, lscl_pkg::ADDR_ROW_HI, 32'h0);
    chk(rd, 32'h0000_0000);
    chk(seg_rows, 160'h0);
    apb(1'b1, lscl_pkg::ADDR_CTRL, 32'h31);
    cmd4(lscl_pkg::OP_BLANK);
    chk(seg_rows, 160'h0);
    chk(display_blank, 1'b1);
    cmd4(lscl_pkg::OP_UNBLANK);
    chk(seg_rows, rows);
    host_u.pin_reset();
    repeat (5) @(posedge core_clk);
    chk(display_blank, 1'b1);
    chk(seg_rows, 160'h0);
    cmd4(lscl_pkg::OP_UNBLANK);
    chk(seg_rows, rows);
    report_and_stop();
  end
endmodule : test_lcd_serial_command_latch

`default_nettype wire
